// ==== verilog/fgac_top.sv ====
// Frame-gated acquisition control: arming, record capture, footers, format
// Contract
// - Selected edge of aux input pulse arms capture of one frame.
// - Software force-arm acts exactly like a hardware arm edge.
// - Armed: take triggers until lines-per-frame records, then await next arm.
// - Aux-output mode drives a chosen internal signal; only force-arm arms.
// - Infinite record count: one start keeps capturing frames until abort.
// - Footer mode: aux edges count frames; frame number appended per record.
// - Footers only in no-pretrigger mode, never otherwise.
// - Slaves configured first; only master takes start; all acquire together.
// - Default output unsigned: 0 negative, 128 zero, 255 positive full scale.
// - Signed output two's complement: 0 zero, 127 and -128 full scale.
// - Host writes format select before start; device reports it on read.
// - Sample code sits in the most significant bits of a 16-bit word.
// - Two-byte words carry low byte at lower address, little-endian.
//
// Local design decisions: the register addresses and strobed register access.
module fgac_top #(
    parameter int ADC_W = fgac_pkg::ADC_W_DEF,
    parameter int SAMP_W = 24,
    parameter int LINE_W = 16,
    parameter int MIN_SAMPS = fgac_pkg::MIN_SAMPS_DEF,
    parameter int SAMP_ALIGN_LOG2 = fgac_pkg::SAMP_ALIGN_LOG2_DEF,
    parameter int PRE_ALIGN_LOG2 = fgac_pkg::PRE_ALIGN_LOG2_DEF
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [fgac_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fgac_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [fgac_pkg::DATA_W-1:0] reg_rdata,
    input wire logic aux_in,
    output logic aux_out,
    output logic aux_oe,
    input wire logic trigger_pin,
    input wire logic start_in_pin,
    output logic start_out,
    input wire logic [ADC_W-1:0] adc_code,
    input wire logic adc_valid,
    output logic [fgac_pkg::WORD_W-1:0] sample_word,
    output logic sample_valid,
    output logic sample_footer,
    output logic record_end
);
    localparam int PAD = fgac_pkg::WORD_W - ADC_W;
    localparam logic [SAMP_W-1:0] SAMP_ONE = SAMP_W'(1);
    localparam logic [LINE_W-1:0] LINE_ONE = LINE_W'(1);
    localparam logic [fgac_pkg::REC_W-1:0] REC_ONE = 1;
    localparam logic [SAMP_W-1:0] MIN_S = SAMP_W'(MIN_SAMPS);
    localparam logic [ADC_W-1:0] MSB_MASK = {1'b1, {(ADC_W-1){1'b0}}};

    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Pin synchronisers: [0] first stage, [1] second stage, [2] history
    logic [2:0] aux_sync_q;
    logic [2:0] trig_sync_q;
    logic [2:0] start_sync_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aux_sync_q <= 3'h0;
            trig_sync_q <= 3'h0;
            start_sync_q <= 3'h0;
        end else begin
            aux_sync_q <= {aux_sync_q[1:0], aux_in};
            trig_sync_q <= {trig_sync_q[1:0], trigger_pin};
            start_sync_q <= {start_sync_q[1:0], start_in_pin};
        end
    end

    logic [fgac_pkg::MODE_W-1:0] mode_q;
    logic [LINE_W-1:0] lines_q;
    logic [fgac_pkg::REC_W-1:0] recs_q;
    logic [SAMP_W-1:0] samps_q;
    logic [SAMP_W-1:0] pretrig_q;
    fgac_pkg::fgac_state_t state_q;
    fgac_pkg::fgac_state_t after_rec;
    logic [SAMP_W-1:0] samp_cnt_q;
    logic [LINE_W-1:0] line_cnt_q;
    logic [fgac_pkg::REC_W-1:0] rec_total_q;
    logic [fgac_pkg::WORD_W-1:0] frame_num_q;
    logic signed_act_q;
    logic footer_act_q;

    fgac_pkg::fgac_aux_mode_t aux_mode;
    fgac_pkg::fgac_aux_src_t aux_src;
    assign aux_mode = fgac_pkg::fgac_aux_mode_t'(
        mode_q[fgac_pkg::MODE_AUX_LSB +: fgac_pkg::MODE_AUX_W]);
    assign aux_src = fgac_pkg::fgac_aux_src_t'(
        mode_q[fgac_pkg::MODE_SRC_LSB +: fgac_pkg::MODE_SRC_W]);

    logic cmd_wr;
    logic start_cmd;
    logic abort_cmd;
    logic force_cmd;
    logic is_slave;
    logic start_evt;
    logic aux_edge;
    logic trig_edge;
    logic arm_evt;
    logic frame_cnt_mode;
    logic footer_ok;
    logic cfg_err;
    logic armed;
    logic last_samp;
    logic rec_done;
    logic last_rec;
    logic frame_full;
    logic infinite;

    assign cmd_wr = reg_wr && reg_addr == fgac_pkg::OFS_CMD;
    assign start_cmd = cmd_wr && reg_wdata[fgac_pkg::CMD_START];
    assign abort_cmd = cmd_wr && reg_wdata[fgac_pkg::CMD_ABORT];
    assign force_cmd = cmd_wr && reg_wdata[fgac_pkg::CMD_FORCE];
    assign is_slave = mode_q[fgac_pkg::MODE_SLAVE];
    // A slave starts only from the master's line, never from software
    assign start_evt = is_slave ? (start_sync_q[1] && !start_sync_q[2])
                                : start_cmd;
    assign aux_edge = mode_q[fgac_pkg::MODE_EDGE]
                    ? (!aux_sync_q[1] && aux_sync_q[2])
                    : (aux_sync_q[1] && !aux_sync_q[2]);
    assign trig_edge = trig_sync_q[1] && !trig_sync_q[2];
    assign frame_cnt_mode = aux_mode == fgac_pkg::FGAC_AUX_FRAME_CNT;
    // Aux edges arm only in arm-input mode; force arms in every mode
    assign arm_evt = force_cmd ||
        (aux_mode == fgac_pkg::FGAC_AUX_ARM_IN && aux_edge);
    assign footer_ok = frame_cnt_mode && mode_q[fgac_pkg::MODE_FOOTER] &&
                       mode_q[fgac_pkg::MODE_NPT];
    // Geometry faults are only flagged: records would shift, not fail
    assign cfg_err = samps_q < MIN_S ||
        samps_q[SAMP_ALIGN_LOG2-1:0] != '0 ||
        (!mode_q[fgac_pkg::MODE_NPT] &&
         pretrig_q[PRE_ALIGN_LOG2-1:0] != '0);
    assign armed = state_q == fgac_pkg::FGAC_WAIT_TRIG ||
                   state_q == fgac_pkg::FGAC_CAPTURE ||
                   state_q == fgac_pkg::FGAC_FOOTER;
    assign last_samp = state_q == fgac_pkg::FGAC_CAPTURE && adc_valid &&
                       samp_cnt_q == samps_q - SAMP_ONE;
    assign rec_done = (last_samp && !footer_act_q) ||
                      state_q == fgac_pkg::FGAC_FOOTER;
    assign infinite = recs_q == fgac_pkg::REC_INFINITE;
    assign last_rec = !infinite && rec_total_q == recs_q - REC_ONE;
    assign frame_full = line_cnt_q == lines_q - LINE_ONE;

    always_comb begin
        if (last_rec) begin
            after_rec = fgac_pkg::FGAC_IDLE;
        end else if (frame_full && !frame_cnt_mode) begin
            after_rec = fgac_pkg::FGAC_WAIT_ARM;
        end else begin
            after_rec = fgac_pkg::FGAC_WAIT_TRIG;
        end
    end

    // Configuration registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= fgac_pkg::MODE_RST;
            lines_q <= fgac_pkg::LINES_RST[LINE_W-1:0];
            recs_q <= fgac_pkg::RECS_RST;
            samps_q <= fgac_pkg::SAMPS_RST[SAMP_W-1:0];
            pretrig_q <= fgac_pkg::PRETRIG_RST[SAMP_W-1:0];
        end else if (reg_wr) begin
            unique case (reg_addr)
                fgac_pkg::OFS_MODE:
                    mode_q <= reg_wdata[fgac_pkg::MODE_W-1:0];
                fgac_pkg::OFS_LINES: lines_q <= reg_wdata[LINE_W-1:0];
                fgac_pkg::OFS_RECS: recs_q <= reg_wdata;
                fgac_pkg::OFS_SAMPS: samps_q <= reg_wdata[SAMP_W-1:0];
                fgac_pkg::OFS_PRETRIG: pretrig_q <= reg_wdata[SAMP_W-1:0];
                default: ;
            endcase
        end
    end

    // Format and footer choice are frozen for the whole acquisition
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            signed_act_q <= 1'b0;
            footer_act_q <= 1'b0;
        end else if (state_q == fgac_pkg::FGAC_IDLE && start_evt) begin
            signed_act_q <= mode_q[fgac_pkg::MODE_SIGNED];
            footer_act_q <= footer_ok;
        end
    end

    // Acquisition sequencer; abort wins over everything
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= fgac_pkg::FGAC_IDLE;
        end else if (abort_cmd) begin
            state_q <= fgac_pkg::FGAC_IDLE;
        end else begin
            unique case (state_q)
                fgac_pkg::FGAC_IDLE:
                    if (start_evt) begin
                        state_q <= frame_cnt_mode ? fgac_pkg::FGAC_WAIT_TRIG
                                                  : fgac_pkg::FGAC_WAIT_ARM;
                    end
                fgac_pkg::FGAC_WAIT_ARM:
                    if (arm_evt) begin
                        state_q <= fgac_pkg::FGAC_WAIT_TRIG;
                    end
                fgac_pkg::FGAC_WAIT_TRIG:
                    if (trig_edge) begin
                        state_q <= fgac_pkg::FGAC_CAPTURE;
                    end
                fgac_pkg::FGAC_CAPTURE:
                    if (last_samp) begin
                        state_q <= footer_act_q ? fgac_pkg::FGAC_FOOTER
                                                : after_rec;
                    end
                fgac_pkg::FGAC_FOOTER: state_q <= after_rec;
                default: state_q <= fgac_pkg::FGAC_IDLE;
            endcase
        end
    end

    // Sample count restarts on each accepted trigger only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            samp_cnt_q <= '0;
        end else if (state_q == fgac_pkg::FGAC_WAIT_TRIG && trig_edge) begin
            samp_cnt_q <= '0;
        end else if (state_q == fgac_pkg::FGAC_CAPTURE && adc_valid) begin
            samp_cnt_q <= samp_cnt_q + SAMP_ONE;
        end
    end

    // Record counts: never touched by triggers outside an armed frame
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            line_cnt_q <= '0;
            rec_total_q <= '0;
        end else if (state_q == fgac_pkg::FGAC_IDLE) begin
            line_cnt_q <= '0;
            rec_total_q <= '0;
        end else if (rec_done) begin
            line_cnt_q <= frame_full ? '0 : line_cnt_q + LINE_ONE;
            rec_total_q <= rec_total_q + REC_ONE;
        end
    end

    // Frame number: aux edges in counting mode, accepted arms otherwise
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            frame_num_q <= '0;
        end else if (state_q == fgac_pkg::FGAC_IDLE) begin
            if (start_evt) begin
                frame_num_q <= '0;
            end
        end else if (frame_cnt_mode ? aux_edge
                     : (state_q == fgac_pkg::FGAC_WAIT_ARM && arm_evt)) begin
            frame_num_q <= frame_num_q + 1'b1;
        end
    end

    // Sample words: code in MSBs, bit 7..0 is the lower-address byte
    logic [ADC_W-1:0] code_fmt;
    logic [fgac_pkg::WORD_W-1:0] code_word;
    assign code_fmt = signed_act_q ? (adc_code ^ MSB_MASK)
                                   : adc_code;
    assign code_word = fgac_pkg::WORD_W'(code_fmt) << PAD;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sample_word <= '0;
            sample_valid <= 1'b0;
            sample_footer <= 1'b0;
            record_end <= 1'b0;
        end else begin
            sample_valid <= 1'b0;
            sample_footer <= 1'b0;
            record_end <= 1'b0;
            if (state_q == fgac_pkg::FGAC_CAPTURE && adc_valid &&
                !abort_cmd) begin
                sample_word <= code_word;
                sample_valid <= 1'b1;
                record_end <= last_samp && !footer_act_q;
            end else if (state_q == fgac_pkg::FGAC_FOOTER && !abort_cmd) begin
                sample_word <= frame_num_q;
                sample_valid <= 1'b1;
                sample_footer <= 1'b1;
                record_end <= 1'b1;
            end
        end
    end

    // Aux connector drive and master start fan-out
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aux_out <= 1'b0;
            aux_oe <= 1'b0;
            start_out <= 1'b0;
        end else begin
            aux_oe <= aux_mode == fgac_pkg::FGAC_AUX_OUT;
            unique case (aux_src)
                fgac_pkg::FGAC_SRC_ARMED: aux_out <= armed;
                fgac_pkg::FGAC_SRC_BUSY:
                    aux_out <= state_q != fgac_pkg::FGAC_IDLE;
                fgac_pkg::FGAC_SRC_RECORD:
                    aux_out <= state_q == fgac_pkg::FGAC_CAPTURE;
                fgac_pkg::FGAC_SRC_TRIG: aux_out <= trig_sync_q[1];
            endcase
            start_out <= start_cmd && !is_slave;
        end
    end

    // Read port: data valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            unique case (reg_addr)
                fgac_pkg::OFS_MODE:
                    reg_rdata[fgac_pkg::MODE_W-1:0] <= mode_q;
                fgac_pkg::OFS_LINES: reg_rdata[LINE_W-1:0] <= lines_q;
                fgac_pkg::OFS_RECS: reg_rdata <= recs_q;
                fgac_pkg::OFS_SAMPS: reg_rdata[SAMP_W-1:0] <= samps_q;
                fgac_pkg::OFS_PRETRIG: reg_rdata[SAMP_W-1:0] <= pretrig_q;
                fgac_pkg::OFS_STATUS: begin
                    reg_rdata[fgac_pkg::STAT_BUSY] <=
                        state_q != fgac_pkg::FGAC_IDLE;
                    reg_rdata[fgac_pkg::STAT_ARMED] <= armed;
                    reg_rdata[fgac_pkg::STAT_CAPT] <=
                        state_q == fgac_pkg::FGAC_CAPTURE;
                    reg_rdata[fgac_pkg::STAT_CFGERR] <= cfg_err;
                end
                fgac_pkg::OFS_FRAME:
                    reg_rdata[fgac_pkg::WORD_W-1:0] <= frame_num_q;
                fgac_pkg::OFS_COUNT: reg_rdata <= rec_total_q;
                default: ;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    a_aux_edge_arms: assert property (
        state_q == fgac_pkg::FGAC_WAIT_ARM && !abort_cmd && aux_edge &&
        aux_mode == fgac_pkg::FGAC_AUX_ARM_IN
        |=> state_q == fgac_pkg::FGAC_WAIT_TRIG)
        else $error("aux edge did not arm");

    a_force_arms: assert property (
        state_q == fgac_pkg::FGAC_WAIT_ARM && force_cmd && !abort_cmd
        |=> state_q == fgac_pkg::FGAC_WAIT_TRIG ##1
            (armed || $past(abort_cmd)))
        else $error("force arm did not arm");

    a_frame_closes: assert property (
        rec_done && frame_full && !last_rec && !frame_cnt_mode && !abort_cmd
        |=> state_q == fgac_pkg::FGAC_WAIT_ARM && line_cnt_q == '0)
        else $error("frame did not close after lines per frame");

    a_aux_out_drive: assert property (
        aux_mode == fgac_pkg::FGAC_AUX_OUT ##1
        aux_mode == fgac_pkg::FGAC_AUX_OUT
        |-> aux_oe && !(state_q == fgac_pkg::FGAC_WAIT_TRIG &&
            $past(state_q) == fgac_pkg::FGAC_WAIT_ARM && !$past(force_cmd)))
        else $error("aux output mode misbehaves");

    a_infinite_runs: assert property (
        rec_done && infinite && !abort_cmd
        |=> state_q != fgac_pkg::FGAC_IDLE)
        else $error("infinite acquisition stopped");

    a_frame_count: assert property (
        state_q != fgac_pkg::FGAC_IDLE && frame_cnt_mode && aux_edge
        |=> frame_num_q == $past(frame_num_q) + 1'b1)
        else $error("frame number not advanced by aux edge");

    a_footer_npt: assert property (
        sample_footer |-> footer_act_q && sample_valid && record_end)
        else $error("footer emitted outside no-pretrigger mode");

    a_start_fanout: assert property (
        start_cmd && !is_slave |=> start_out ##1
            (!start_out || $past(start_cmd)))
        else $error("master start not distributed");

    a_unsigned_code: assert property (
        sample_valid && !sample_footer && !signed_act_q
        |-> sample_word == fgac_pkg::WORD_W'($past(adc_code)) << PAD)
        else $error("unsigned sample word wrong");

    a_signed_code: assert property (
        sample_valid && !sample_footer && signed_act_q
        |-> sample_word[fgac_pkg::WORD_W-1] != $past(adc_code[ADC_W-1]))
        else $error("signed sample word wrong");

    a_format_read: assert property (
        reg_rd && reg_addr == fgac_pkg::OFS_MODE
        |=> reg_rdata[fgac_pkg::MODE_SIGNED] ==
            $past(mode_q[fgac_pkg::MODE_SIGNED]))
        else $error("format select not reported");

    a_msb_aligned: assert property (
        sample_valid && !sample_footer
        |-> (sample_word & ~(fgac_pkg::WORD_W'({ADC_W{1'b1}}) << PAD)) == '0)
        else $error("sample code not in upper bits");

    a_trig_ignored: assert property (
        !armed && trig_edge |=> state_q != fgac_pkg::FGAC_CAPTURE &&
        rec_total_q <= $past(rec_total_q))
        else $error("trigger accepted while not armed");
endmodule

// ==== verilog/fgac_pkg.sv ====
// Shared constants and types for the frame-gated acquisition control block
package fgac_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int MODE_W = 16;
    localparam int REC_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LINES = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RECS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SAMPS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PRETRIG = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FRAME = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h20;

    // Command register bits (write-only pulses)
    localparam int CMD_START = 0;
    localparam int CMD_ABORT = 1;
    localparam int CMD_FORCE = 2;

    // Mode register fields
    localparam int MODE_AUX_LSB = 0;
    localparam int MODE_AUX_W = 2;
    localparam int MODE_EDGE = 2;
    localparam int MODE_NPT = 3;
    localparam int MODE_FOOTER = 4;
    localparam int MODE_SIGNED = 5;
    localparam int MODE_SLAVE = 6;
    localparam int MODE_SRC_LSB = 8;
    localparam int MODE_SRC_W = 2;

    // Status register bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_ARMED = 1;
    localparam int STAT_CAPT = 2;
    localparam int STAT_CFGERR = 3;

    // Reset values and the record count that means infinite
    localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;
    localparam logic [DATA_W-1:0] LINES_RST = 32'h0000_0001;
    localparam logic [REC_W-1:0] RECS_RST = 32'h0000_0001;
    localparam logic [DATA_W-1:0] SAMPS_RST = 32'h0000_0100;
    localparam logic [DATA_W-1:0] PRETRIG_RST = 32'h0000_0000;
    localparam logic [REC_W-1:0] REC_INFINITE = 32'hFFFF_FFFF;

    // Default ADC width and defaults of the record geometry checks
    localparam int ADC_W_DEF = 12;
    localparam int MIN_SAMPS_DEF = 256;
    localparam int SAMP_ALIGN_LOG2_DEF = 5;
    localparam int PRE_ALIGN_LOG2_DEF = 4;

    typedef enum logic [MODE_AUX_W-1:0] {
        FGAC_AUX_ARM_IN,
        FGAC_AUX_OUT,
        FGAC_AUX_FRAME_CNT
    } fgac_aux_mode_t;

    typedef enum logic [MODE_SRC_W-1:0] {
        FGAC_SRC_ARMED,
        FGAC_SRC_BUSY,
        FGAC_SRC_RECORD,
        FGAC_SRC_TRIG
    } fgac_aux_src_t;

    typedef enum logic [2:0] {
        FGAC_IDLE,
        FGAC_WAIT_ARM,
        FGAC_WAIT_TRIG,
        FGAC_CAPTURE,
        FGAC_FOOTER
    } fgac_state_t;
endpackage

// ==== tb/fgac_src_model.sv ====
// External TTL frame source: arm pulses on aux, record trigger pulses
module fgac_src_model (
    input wire logic clock,
    input wire logic aux_out,
    input wire logic aux_oe,
    output logic aux_in,
    output logic trigger_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic aux_q = 1'b0;
    initial trigger_pin = 1'b0;
    // The device owns the wire while it drives it
    assign aux_in = aux_oe ? aux_out : aux_q;
    task automatic pulse(input bit on_aux);
        if (on_aux) begin
            aux_q <= 1'b1;
        end else begin
            trigger_pin <= 1'b1;
        end
        repeat (4) @(posedge clock);
        aux_q <= 1'b0;
        trigger_pin <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
endmodule

// ==== tb/fgac_top_tb_top.sv ====
// Self-checking bench for the frame-gated acquisition control block
module fgac_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic adc_valid = 1, start_in_pin = 0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic [31:0] reg_rdata;
    logic [11:0] adc_code = '0;
    logic aux_in, aux_out, aux_oe, trigger_pin, start_out;
    logic [15:0] sample_word;
    logic sample_valid, sample_footer, record_end;
    logic [17:0] wq[$];
    int n_errors = 0, compares = 0, cyc = 0, n_start = 0;
    fgac_top dut_u (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .aux_in(aux_in), .aux_out(aux_out),
        .aux_oe(aux_oe), .trigger_pin(trigger_pin),
        .start_in_pin(start_in_pin), .start_out(start_out),
        .adc_code(adc_code), .adc_valid(adc_valid),
        .sample_word(sample_word), .sample_valid(sample_valid),
        .sample_footer(sample_footer), .record_end(record_end)
    );
    fgac_src_model src_u (
        .clock(clock), .aux_out(aux_out), .aux_oe(aux_oe),
        .aux_in(aux_in), .trigger_pin(trigger_pin)
    );
    always #5 clock = ~clock;
    // Collect every output word with its end and footer flags
    always @(posedge clock) begin
        cyc++;
        if (sample_valid === 1'b1)
            wq.push_back({record_end, sample_footer, sample_word});
        if (start_out === 1'b1)
            n_start++;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task end_of_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk("reg", e, reg_rdata);
        @(posedge clock);
    endtask
    // Bounded wait: an ignored trigger simply runs the bound out
    task trig(input logic [11:0] c);
        int k;
        adc_code <= c;
        src_u.pulse(1'b0);
        for (k = 0; k < 300 && record_end !== 1'b1; k++) @(posedge clock);
        repeat (3) @(posedge clock);
    endtask
    // Legal 256-sample records, collected from an aligned word 0
    task chk_rec(input logic [15:0] w, input bit f, input logic [15:0] fn);
        int i, n;
        n = wq.size();
        chk("words", 256 + f, n);
        for (i = 0; i < n; i++)
            chk("word", {i == n - 1,
                (f && i == n - 1) ? {1'b1, fn} : {1'b0, w}}, wq[i]);
        wq.delete();
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h1);
        rd(8'h0C, 32'h1);
        rd(8'h10, 32'h100);
        rd(8'h14, 32'h0);
        rd(8'h40, 32'h0);
        wr(8'h08, 32'h2);
        wr(8'h0C, 32'h3);
        wr(8'h00, 32'h1);
        trig(12'h800);
        chk("words", 0, wq.size());
        wr(8'h00, 32'h4);
        trig(12'h800);
        chk_rec(16'h8000, 0, 0);
        trig(12'h7FE);
        chk_rec(16'h7FE0, 0, 0);
        trig(12'h800);
        chk("words", 0, wq.size());
        rd(8'h20, 32'h2);
        src_u.pulse(1'b1);
        trig(12'hFFF);
        chk_rec(16'hFFF0, 0, 0);
        rd(8'h20, 32'h0);
        rd(8'h18, 32'h0);
        wr(8'h04, 32'h21);
        rd(8'h04, 32'h21);
        wr(8'h08, 32'h1);
        wr(8'h0C, 32'hFFFF_FFFF);
        wr(8'h00, 32'h1);
        chk("aux_oe", 1, aux_oe);
        src_u.pulse(1'b1);
        trig(12'h800);
        chk("words", 0, wq.size());
        wr(8'h00, 32'h4);
        #1 chk("aux_out", 1, aux_out);
        @(posedge clock);
        trig(12'h800);
        chk_rec(16'h0000, 0, 0);
        wr(8'h00, 32'h4);
        trig(12'h7FF);
        chk_rec(16'hFFF0, 0, 0);
        wr(8'h00, 32'h2);
        rd(8'h18, 32'h0);
        wr(8'h04, 32'h1A);
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h1);
        src_u.pulse(1'b1);
        src_u.pulse(1'b1);
        trig(12'h800);
        chk_rec(16'h8000, 1, 16'h2);
        wr(8'h04, 32'h12);
        wr(8'h00, 32'h1);
        trig(12'h800);
        chk_rec(16'h8000, 0, 0);
        wr(8'h04, 32'h40);
        wr(8'h00, 32'h1);
        rd(8'h18, 32'h0);
        start_in_pin <= 1'b1;
        repeat (4) @(posedge clock);
        rd(8'h18, 32'h1);
        chk("start_out", 4, n_start);
        end_of_test();
    end
endmodule
